// ===== core/op_decode_pkg.sv
// Constants and carrier types for the add, and, branch and bit-clear execute block
// Overview of operation
// [RL1] Add accumulator, register and carry to destination
// [RL2] Add updates negative, overflow, carry, nibble, zero
// [RL3] Destination bit zero accumulator, one register
// [RL4] Bank bit zero fixed bank, else pointer
// [RL5] AND literal into accumulator
// [RL6] AND changes only negative and zero flags
// [RL7] AND accumulator with register to destination
// [RL8] Branch only when carry set, signed offset
// [RL9] Taken target is address plus two plus 2n
// [RL10] Branch decoded from upper byte 1110 0010
// [RL11] Branch one word, one or two cycles
// [RL12] Branch and bit clear leave flags alone
// [RL13] Clear selected bit of addressed register
// [RL14] Quarter phases: decode, read, compute, write
package op_decode_pkg;
  // Opcode patterns, compared against the upper bits of the word
  localparam logic [5:0] OP_ADD_CARRY = 6'h08;   // 0010 00
  localparam logic [5:0] OP_AND_FILE  = 6'h05;   // 0001 01
  localparam logic [7:0] OP_AND_LIT   = 8'h0b;   // 0000 1011
  localparam logic [7:0] OP_BR_CARRY  = 8'he2;   // 1110 0010
  localparam logic [3:0] OP_BIT_CLR   = 4'h9;    // 1001
  // Field positions inside the instruction word
  localparam int DEST_BIT   = 9;
  localparam int BANK_BIT   = 8;
  localparam int BITSEL_LSB = 9;
  // Status bit positions
  localparam int FL_CARRY = 0;
  localparam int FL_DC    = 1;
  localparam int FL_ZERO  = 2;
  localparam int FL_OV    = 3;
  localparam int FL_NEG   = 4;
  // Reset values
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [4:0]  STATUS_RST = 5'h00;
  localparam logic [20:0] PC_RST     = 21'h000000;
  localparam logic [20:0] PC_STEP    = 21'h000002;

  // Quarter phases of one instruction cycle, one-hot
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } phase_t;

  // Operation chosen by the decoder
  typedef enum logic [5:0] {
    OPS_NONE  = 6'h01,
    OPS_ADDC  = 6'h02,
    OPS_ANDL  = 6'h04,
    OPS_ANDF  = 6'h08,
    OPS_BRC   = 6'h10,
    OPS_BCLR  = 6'h20
  } op_sel_t;

  // Data memory request toward the register file
  typedef struct packed {
    logic        rd;     // Read strobe in the second phase
    logic        wr;     // Write strobe in the fourth phase
    logic [11:0] addr;   // Banked address
    logic [7:0]  wdata;  // Write data
  } mem_req_t;

  // Status flags, carried together
  typedef struct packed {
    logic neg;
    logic ov;
    logic zero;
    logic dc;
    logic carry;
  } status_t;
endpackage

// ===== core/op_alu.sv
// Combinational arithmetic and logic unit for the execute block
`timescale 1ns/1ps
module op_alu (
  input  wire op_decode_pkg::op_sel_t op,
  input  wire logic [7:0]            acc,
  input  wire logic [7:0]            opnd,
  input  wire logic [2:0]            bit_sel,
  input  wire op_decode_pkg::status_t st_in,
  output      logic [7:0]            result,
  output op_decode_pkg::status_t     st_out
);
  // Sums for the add, split at the nibble for the digit carry
  wire [4:0] low_sum  = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, st_in.carry};
  wire [8:0] full_sum = {1'b0, acc} + {1'b0, opnd} + {8'h00, st_in.carry}; // RL1
  wire [7:0] and_res  = acc & opnd;                                        // RL5
  wire [7:0] clr_mask = ~(8'h01 << bit_sel);                                // RL13
  wire       add_ov   = (acc[7] == opnd[7]) && (full_sum[7] != acc[7]);

  // Result and flag selection
  always_comb begin
    result = opnd;
    st_out = st_in;                            // RL12
    unique case (op)
      op_decode_pkg::OPS_ADDC: begin
        result       = full_sum[7:0];
        st_out.carry = full_sum[8];            // RL2
        st_out.dc    = low_sum[4];             // RL2
        st_out.ov    = add_ov;                 // RL2
        st_out.neg   = full_sum[7];            // RL2
        st_out.zero  = (full_sum[7:0] == 8'h00); // RL2
      end
      op_decode_pkg::OPS_ANDL,
      op_decode_pkg::OPS_ANDF: begin
        result      = and_res;
        st_out.neg  = and_res[7];              // RL6
        st_out.zero = (and_res == 8'h00);      // RL6
      end
      op_decode_pkg::OPS_BCLR: begin
        result = opnd & clr_mask;              // RL13
      end
      default: begin
        result = opnd;
      end
    endcase
  end
endmodule

// ===== core/op_exec.sv
// Four-phase decode and execute for add-with-carry, the ANDs, branch on carry, bit clear
`timescale 1ns/1ps
module op_exec #(
  parameter int PC_W = 21
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic [15:0]            instr,
  input  wire logic [PC_W-1:0]        instr_addr,
  input  wire logic [3:0]             bank_pointer,
  input  wire logic [3:0]             fixed_bank,
  input  wire logic [7:0]             mem_rdata,
  output      op_decode_pkg::mem_req_t mem_req,
  output      logic [7:0]             acc,
  output      op_decode_pkg::status_t status,
  output      logic [PC_W-1:0]        pc,
  output      logic                   pc_load,
  output      logic                   busy,
  output      logic [3:0]             phase
);
  op_decode_pkg::phase_t   ph_q;          // Current quarter phase
  op_decode_pkg::phase_t   ph_d;
  op_decode_pkg::op_sel_t  op_q;          // Operation latched at decode
  op_decode_pkg::op_sel_t  op_dec;
  logic [15:0]             ir_q;          // Instruction under execution
  logic [7:0]              opnd_q;        // Operand read in the second phase
  logic [7:0]              res_q;         // Result formed in the third phase
  op_decode_pkg::status_t  st_new_q;      // Flags formed in the third phase
  logic [7:0]              alu_res;
  op_decode_pkg::status_t  alu_st;
  logic [7:0]              acc_q;         // Accumulator
  op_decode_pkg::status_t  st_q;          // Status flags
  logic [PC_W-1:0]         pc_q;          // Program counter copy
  logic                    pc_load_q;     // One-phase pulse on a taken branch
  logic                    nop_q;         // Second cycle of a taken branch
  op_decode_pkg::mem_req_t req_q;

  // Decode of the incoming word
  wire is_addc = instr[15:10] == op_decode_pkg::OP_ADD_CARRY;   // RL1
  wire is_andf = instr[15:10] == op_decode_pkg::OP_AND_FILE;    // RL7
  wire is_andl = instr[15:8] == op_decode_pkg::OP_AND_LIT;      // RL5
  wire is_brc  = instr[15:8] == op_decode_pkg::OP_BR_CARRY;     // RL10
  wire is_bclr = instr[15:12] == op_decode_pkg::OP_BIT_CLR;     // RL13
  assign op_dec = is_addc ? op_decode_pkg::OPS_ADDC :
                  is_andf ? op_decode_pkg::OPS_ANDF :
                  is_andl ? op_decode_pkg::OPS_ANDL :
                  is_brc  ? op_decode_pkg::OPS_BRC  :
                  is_bclr ? op_decode_pkg::OPS_BCLR : op_decode_pkg::OPS_NONE;

  // Operand class of the latched instruction
  wire uses_file = (op_q == op_decode_pkg::OPS_ADDC) || (op_q == op_decode_pkg::OPS_ANDF)
                   || (op_q == op_decode_pkg::OPS_BCLR);
  wire to_file   = (op_q == op_decode_pkg::OPS_BCLR) ||
                   (uses_file && ir_q[op_decode_pkg::DEST_BIT]);             // RL3
  wire to_acc    = ((op_q == op_decode_pkg::OPS_ADDC) || (op_q == op_decode_pkg::OPS_ANDF))
                   ? !ir_q[op_decode_pkg::DEST_BIT]                          // RL3
                   : (op_q == op_decode_pkg::OPS_ANDL);
  wire flags_wr  = (op_q == op_decode_pkg::OPS_ADDC) || (op_q == op_decode_pkg::OPS_ANDF)
                   || (op_q == op_decode_pkg::OPS_ANDL);                     // RL12

  // Banked register address: bank-access bit low picks the fixed bank, else the pointer
  function automatic logic [11:0] banked_addr(
    input logic [15:0] w,
    input logic [3:0]  ptr,
    input logic [3:0]  fix
  );
    return {(w[op_decode_pkg::BANK_BIT] ? ptr : fix), w[7:0]};  // RL4
  endfunction

  // Bank selection for the register address of the latched word
  wire [11:0] f_addr   = banked_addr(ir_q, bank_pointer, fixed_bank); // RL4

  // Branch target: own address plus two plus twice the signed offset
  wire [PC_W-1:0] br_off    = PC_W'({{(PC_W-8){ir_q[7]}}, ir_q[7:0]} <<< 1);
  wire [PC_W-1:0] br_target = instr_addr + PC_W'(op_decode_pkg::PC_STEP) + br_off; // RL9
  wire            br_take   = (op_q == op_decode_pkg::OPS_BRC) && st_q.carry;       // RL8

  // Arithmetic unit
  op_alu u_alu (
    .op      (op_q),
    .acc     (acc_q),
    .opnd    (opnd_q),
    .bit_sel (ir_q[op_decode_pkg::BITSEL_LSB +: 3]),
    .st_in   (st_q),
    .result  (alu_res),
    .st_out  (alu_st)
  );

  // Phase sequencer
  always_comb begin
    unique case (ph_q)
      op_decode_pkg::PH_Q1: ph_d = op_decode_pkg::PH_Q2;
      op_decode_pkg::PH_Q2: ph_d = op_decode_pkg::PH_Q3;
      op_decode_pkg::PH_Q3: ph_d = op_decode_pkg::PH_Q4;
      op_decode_pkg::PH_Q4: ph_d = op_decode_pkg::PH_Q1;
      default:              ph_d = op_decode_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_q <= op_decode_pkg::PH_Q1;
    end else begin
      ph_q <= ph_d;                                                 // RL14
    end
  end

  // Decode in the first phase; a taken branch turns the next cycle into a no-op
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_q  <= op_decode_pkg::OPS_NONE;
      ir_q  <= 16'h0000;
      nop_q <= 1'b0;
    end else if (ph_q == op_decode_pkg::PH_Q1) begin
      op_q  <= nop_q ? op_decode_pkg::OPS_NONE : op_dec;            // RL11
      ir_q  <= instr;                                               // RL14
      nop_q <= 1'b0;
    end else if (ph_q == op_decode_pkg::PH_Q4 && br_take) begin
      nop_q <= 1'b1;                                                // RL11
    end
  end

  // Operand read in the second phase, compute in the third
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opnd_q   <= 8'h00;
      res_q    <= 8'h00;
      st_new_q <= op_decode_pkg::STATUS_RST;
    end else if (ph_q == op_decode_pkg::PH_Q2) begin
      opnd_q <= uses_file ? mem_rdata : ir_q[7:0];                  // RL14
    end else if (ph_q == op_decode_pkg::PH_Q3) begin
      res_q    <= alu_res;                                          // RL14
      st_new_q <= alu_st;
    end
  end

  // Write of the destination, flags and program counter in the fourth phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q     <= op_decode_pkg::ACC_RST;
      st_q      <= op_decode_pkg::STATUS_RST;
      pc_q      <= PC_W'(op_decode_pkg::PC_RST);
      pc_load_q <= 1'b0;
    end else begin
      pc_load_q <= 1'b0;
      if (ph_q == op_decode_pkg::PH_Q4) begin
        if (to_acc) begin
          acc_q <= res_q;                                           // RL3
        end
        if (flags_wr) begin
          st_q <= st_new_q;                                         // RL2
        end
        if (br_take) begin
          pc_q      <= br_target;                                   // RL9
          pc_load_q <= 1'b1;
        end
      end
    end
  end

  // Data memory strobes: read in the second phase, write in the fourth
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_q <= '0;
    end else begin
      req_q.rd    <= (ph_d == op_decode_pkg::PH_Q2) && (ph_q == op_decode_pkg::PH_Q1)
                     && ((op_dec == op_decode_pkg::OPS_ADDC) || (op_dec == op_decode_pkg::OPS_ANDF)
                     || (op_dec == op_decode_pkg::OPS_BCLR)) && !nop_q;
      req_q.addr  <= (ph_q == op_decode_pkg::PH_Q1)
                     ? banked_addr(instr, bank_pointer, fixed_bank)
                     : f_addr;                                      // RL4
      req_q.wr    <= (ph_q == op_decode_pkg::PH_Q3) && to_file;     // RL3
      req_q.wdata <= alu_res;
    end
  end

  assign mem_req = req_q;
  assign acc     = acc_q;
  assign status  = st_q;
  assign pc      = pc_q;
  assign pc_load = pc_load_q;
  assign busy    = nop_q;
  assign phase   = ph_q;
endmodule

// ===== verification/op_exec_checker.sv
// Assertion checker for the four-phase execute block
`timescale 1ns/1ps
module op_exec_checker #(
  parameter int PC_W = 21
) (
  input wire logic                    clk,
  input wire logic                    arst_n,
  input wire logic [15:0]             instr,
  input wire logic [PC_W-1:0]         instr_addr,
  input wire logic [3:0]              bank_pointer,
  input wire logic [3:0]              fixed_bank,
  input wire logic [7:0]              mem_rdata,
  input wire op_decode_pkg::mem_req_t mem_req,
  input wire logic [7:0]              acc,
  input wire op_decode_pkg::status_t  status,
  input wire logic [PC_W-1:0]         pc,
  input wire logic                    pc_load,
  input wire logic                    busy,
  input wire logic [3:0]              phase
);
  // Word accepted at the end of Q1, and its kind
  wire            take   = phase == 4'h1 && !busy;
  wire            is_br  = instr[15:8] == 8'he2;
  wire            is_clr = instr[15:12] == 4'h9;
  // Banked address, clear mask, branch target and untouched flags
  wire [11:0]     f_addr = {instr[8] ? bank_pointer : fixed_bank, instr[7:0]};
  wire [7:0]      keep_m = ~(8'h01 << instr[11:9]);
  wire [PC_W-1:0] tgt    = instr_addr + PC_W'(2) + ({{(PC_W-8){instr[7]}}, instr[7:0]} << 1);
  wire [2:0]      ar_fl  = {status.ov, status.dc, status.carry};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_phase_wrap: assert property (phase == 4'h8 |=> phase == 4'h1)
    else $error("phase did not wrap to Q1");
  a_phase_step: assert property (phase != 4'h8 |=> phase == $past(phase) << 1)
    else $error("phase did not advance");
  a_read_q2: assert property (mem_req.rd |-> phase == 4'h2)
    else $error("read strobe outside Q2");
  a_write_q4: assert property (mem_req.wr |-> phase == 4'h8)
    else $error("write strobe outside Q4");
  a_load_busy: assert property (pc_load |-> busy && phase == 4'h1 && $past(phase) == 4'h8)
    else $error("pc load not followed by no-op cycle");
  a_addc_sum: assert property (take && instr[15:9] == 7'h10 |-> ##3 !mem_req.wr ##1
    {status.carry, acc} == {1'b0, $past(acc, 4)} + {1'b0, $past(mem_rdata, 3)}
    + 9'($past(status.carry, 4))) else $error("add with carry result wrong");
  a_and_lit: assert property (take && instr[15:8] == 8'h0b |-> ##4
    acc == ($past(acc, 4) & $past(instr[7:0], 4)) && status.zero == (acc == 8'h00)
    && status.neg == acc[7]) else $error("literal and result wrong");
  a_and_flags: assert property (take && (instr[15:8] == 8'h0b || instr[15:10] == 6'h05)
    |-> ##4 ar_fl == $past(ar_fl, 4)) else $error("and touched arithmetic flags");
  a_flag_hold: assert property (take && (is_br || is_clr) |-> ##4 status == $past(status, 4))
    else $error("branch or bit clear changed flags");
  a_br_taken: assert property (take && is_br && status.carry |-> ##4 pc_load && pc == $past(tgt, 4))
    else $error("taken branch target wrong");
  a_br_skip: assert property (take && is_br && !status.carry |-> ##4 !pc_load && !busy)
    else $error("branch taken without carry");
  a_clr_write: assert property (take && is_clr |-> ##1 mem_req.rd && mem_req.addr == $past(f_addr)
    ##2 mem_req.wr && mem_req.wdata == ($past(mem_rdata, 2) & $past(keep_m, 3)))
    else $error("bit clear write wrong");
  a_andf_dest: assert property (take && instr[15:9] == 7'h0b |-> ##3 mem_req.wr
    && mem_req.wdata == (acc & $past(mem_rdata, 2))) else $error("file and write wrong");
endmodule
bind op_exec op_exec_checker #(.PC_W(PC_W)) u_chk (.clk(clk), .arst_n(arst_n), .instr(instr),
  .instr_addr(instr_addr), .bank_pointer(bank_pointer), .fixed_bank(fixed_bank),
  .mem_rdata(mem_rdata), .mem_req(mem_req), .acc(acc), .status(status), .pc(pc),
  .pc_load(pc_load), .busy(busy), .phase(phase));

// ===== verification/tb_op_exec.sv
// Self-checking bench for the four-phase execute block
`timescale 1ns/1ps
module tb_op_exec;
  logic                    clk, arst_n, pc_load, busy, rd_seen, wr_seen;
  logic [15:0]             instr;
  logic [20:0]             instr_addr, pc;
  logic [3:0]              bank_pointer, fixed_bank, phase;
  logic [7:0]              mem_rdata, acc, wd_seen;
  logic [11:0]             ad_seen;
  op_decode_pkg::mem_req_t mem_req;
  op_decode_pkg::status_t  status;
  int                      n_mismatch, checks_done;
  op_exec DUT (.clk(clk), .arst_n(arst_n), .instr(instr), .instr_addr(instr_addr),
    .bank_pointer(bank_pointer), .fixed_bank(fixed_bank), .mem_rdata(mem_rdata),
    .mem_req(mem_req), .acc(acc), .status(status), .pc(pc), .pc_load(pc_load),
    .busy(busy), .phase(phase));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Present one word for a whole cycle, capturing the Q2 read and Q4 write
  task automatic issue(input logic [15:0] i, input logic [20:0] a, input logic [7:0] rd);
    instr = i;
    instr_addr = a;
    mem_rdata = rd;
    @(posedge clk);
    #1;
    rd_seen = mem_req.rd;
    ad_seen = mem_req.addr;
    repeat (2) @(posedge clk);
    #1;
    wr_seen = mem_req.wr;
    wd_seen = mem_req.wdata;
    @(posedge clk);
    #1;
  endtask
  // Add with carry through every flag but zero, then literal AND, which sets zero
  task automatic t_add_and;
    issue(16'h2010, 21'h0, 8'ha3);
    chk({rd_seen, ad_seen, acc, status}, {1'b1, 12'h310, 8'ha3, 5'h10});
    issue(16'h2010, 21'h0, 8'h60);
    chk({acc, status}, {8'h03, 5'h01});
    issue(16'h0b5f, 21'h0, 8'h00);
    chk({acc, status}, {8'h03, 5'h01});
    issue(16'h0b00, 21'h0, 8'h00);
    chk({acc, status}, {8'h00, 5'h05});
    issue(16'h2010, 21'h0, 8'h7f);
    chk({acc, status, wr_seen}, {8'h80, 5'h1a, 1'b0});
  endtask
  // AND with a file register to both destinations from both banks
  task automatic t_and_file;
    issue(16'h1734, 21'h0, 8'hc2);
    chk({wr_seen, ad_seen, wd_seen, acc}, {1'b1, 12'hc34, 8'h80, 8'h80});
    issue(16'h1434, 21'h0, 8'h0f);
    chk({wr_seen, ad_seen, acc, status}, {1'b0, 12'h334, 8'h00, 5'h0e});
  endtask
  // Clear each bit position in turn, flags untouched
  task automatic t_bit_clear;
    for (int b = 0; b < 8; b++) begin
      issue({4'h9, 3'(b), 1'(b), 8'h47}, 21'h0, 8'hff);
      chk({wr_seen, ad_seen[11:8], wd_seen},
          {1'b1, b[0] ? 4'hc : 4'h3, 8'hff & ~(8'h01 << b)});
      chk({acc, status}, {8'h00, 5'h0e});
    end
  endtask
  // Branch on carry: skipped, taken at both offset limits, shadow word ignored
  task automatic t_branch;
    issue(16'he205, 21'h100, 8'h00);
    chk({pc_load, busy, status}, {2'b00, 5'h0e});
    issue(16'h2010, 21'h0, 8'hff);
    issue(16'h2010, 21'h0, 8'hff);
    chk({acc, status}, {8'hfe, 5'h13});
    issue(16'he280, 21'h100, 8'h00);
    chk({pc_load, busy, pc}, {2'b11, 21'h000002});
    issue(16'h0b00, 21'h0, 8'h00);
    chk({acc, status, pc_load, busy}, {8'hfe, 5'h13, 2'b00});
    issue(16'he27f, 21'h1000, 8'h00);
    chk({pc_load, pc, status}, {1'b1, 21'h001100, 5'h13});
  endtask
  // Reset in mid-cycle: state returns to Q1 and zero, then execution resumes cleanly
  task automatic t_reset;
    instr = 16'h2010;
    mem_rdata = 8'h55;
    @(posedge clk);
    #1;
    arst_n = 1'b0;
    #1;
    chk({phase, acc, status, pc_load, busy}, {4'h1, 8'h00, 5'h00, 2'b00});
    chk(pc, 21'h000000);
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    issue(16'h2010, 21'h0, 8'h05);
    chk({acc, status, phase}, {8'h05, 5'h00, 4'h1});
  endtask
  // Print the counts and the verdict, then stop
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    arst_n = 1'b0;
    instr = 16'h0000;
    instr_addr = 21'h0;
    fixed_bank = 4'h3;
    bank_pointer = 4'hc;
    mem_rdata = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_add_and;
    t_and_file;
    t_bit_clear;
    t_branch;
    t_reset;
    close_out;
  end
  // Watchdog, far beyond the roughly one hundred cycles the tests need
  initial begin
    #20000;
    n_mismatch++;
    close_out;
  end
endmodule
